// ### rtl/debug_port_pkg.sv
package debug_port_pkg;

  // ----------------------------------------
  // Debug register space
  // ----------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [6:0] WR_TOP = 7'h30;
  localparam logic [6:0] RD_TOP = 7'h20;
  localparam logic [3:0] SEP_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ----------------------------------------
  // Local control and status port
  // ----------------------------------------
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] STAT_OFS = 2'h1;
  localparam int CTRL_GRANT_EN_BIT = 0;
  localparam int STAT_GRANT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_READ_BIT = 2;
  localparam logic CTRL_GRANT_EN_RST = 1'b0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int MIN_SERIAL_PERIOD_CYC = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} port_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dbg_access_t;

endpackage : debug_port_pkg

// ### rtl/two_wire_debug_port.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module two_wire_debug_port
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic debug_serial_clock,
  input wire logic debug_serial_data_in,
  output logic debug_serial_data_out,
  output logic debug_serial_data_oe,
  output debug_port_pkg::dbg_access_t dbg_req,
  input wire logic [7:0] dbg_rdata,
  input wire logic bus_request_in,
  output logic bus_grant_out,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A change counts only once the last two stages agree
  function automatic logic agree_lvl(input logic s2, input logic s3, input logic old);
    agree_lvl = (s2 == s3) ? s3 : old;
  endfunction : agree_lvl

  // Address step that sticks at the top of its space
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic [6:0] top);
    step_addr = (a == top) ? a : a + 7'h01;
  endfunction : step_addr

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [2:0] req_sync_r;
  logic scl_lvl_r;
  logic sda_lvl_r;
  logic req_lvl_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      req_sync_r <= 3'h0;
    end
    else if (clk_en)
    begin
      scl_sync_r <= {scl_sync_r[1:0], debug_serial_clock};
      sda_sync_r <= {sda_sync_r[1:0], debug_serial_data_in};
      req_sync_r <= {req_sync_r[1:0], bus_request_in};
    end
  end

  wire scl_new = agree_lvl(scl_sync_r[1], scl_sync_r[2], scl_lvl_r);
  wire sda_new = agree_lvl(sda_sync_r[1], sda_sync_r[2], sda_lvl_r);
  wire req_new = agree_lvl(req_sync_r[1], req_sync_r[2], req_lvl_r);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_lvl_r <= 1'b1;
      sda_lvl_r <= 1'b1;
      req_lvl_r <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_lvl_r <= scl_new;
      sda_lvl_r <= sda_new;
      req_lvl_r <= req_new;
    end
  end

  // ----------------------------------------
  // Edge and start detection
  // ----------------------------------------
  wire scl_rise = scl_new & ~scl_lvl_r;
  wire scl_fall = ~scl_new & scl_lvl_r;
  // Clock must stay high on both sides, so a clock edge is never a start
  // Own read bits can land beside a clock rise after the synchronisers; never a start
  wire start_det = ~sda_new & sda_lvl_r & scl_new & scl_lvl_r
                   & ~debug_serial_data_oe;
  // A data rise with the clock high falls through every branch below
  wire sda_rise_hi = sda_new & ~sda_lvl_r & scl_new & scl_lvl_r;

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  debug_port_pkg::port_state_t state_r;
  debug_port_pkg::port_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic dir_rd_r;
  logic dir_rd_nxt;
  logic sep_hi_r;
  logic sep_hi_nxt;
  logic wr_go;
  logic rd_go;

  wire in_cmd = (state_r == debug_port_pkg::ST_CMD);
  wire in_data = (state_r == debug_port_pkg::ST_DATA);
  wire at_sep = (bit_cnt_r == debug_port_pkg::SEP_SLOT);
  wire at_last = (bit_cnt_r == debug_port_pkg::LAST_BIT);
  wire active = (state_r != debug_port_pkg::ST_IDLE);
  wire bit_edge = scl_rise & active & ~start_det;

  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt = rx_r;
    addr_nxt = addr_r;
    dir_rd_nxt = dir_rd_r;
    sep_hi_nxt = sep_hi_r;
    wr_go = 1'b0;
    rd_go = 1'b0;
    case (state_r)
      debug_port_pkg::ST_IDLE:
      begin
        // Nothing but a start leaves idle
        if (start_det)
        begin
          state_nxt = debug_port_pkg::ST_CMD;
          bit_cnt_nxt = 4'h0;
          sep_hi_nxt = 1'b0;
        end
      end
      debug_port_pkg::ST_CMD, debug_port_pkg::ST_DATA:
      begin
        if (start_det)
        begin
          // A new start abandons whatever was in progress
          state_nxt = debug_port_pkg::ST_CMD;
          bit_cnt_nxt = 4'h0;
          sep_hi_nxt = 1'b0;
        end
        else if (bit_edge)
        begin
          bit_cnt_nxt = at_sep ? 4'h0 : bit_cnt_r + 4'h1;
          if (!at_sep)
          begin
            rx_nxt = {rx_r[6:0], sda_lvl_r};
          end
          if (in_cmd && at_sep)
          begin
            addr_nxt = rx_r[7:1];
            dir_rd_nxt = rx_r[0];
            state_nxt = debug_port_pkg::ST_DATA;
            sep_hi_nxt = sda_lvl_r;
            rd_go = rx_r[0];
          end
          if (in_data && !dir_rd_r && at_last)
          begin
            wr_go = 1'b1;
            addr_nxt = step_addr(addr_r, debug_port_pkg::WR_TOP);
          end
          if (in_data && at_sep)
          begin
            sep_hi_nxt = sda_lvl_r;
            if (dir_rd_r)
            begin
              addr_nxt = step_addr(addr_r, debug_port_pkg::RD_TOP);
              rd_go = 1'b1;
            end
          end
        end
      end
      default:
      begin
        state_nxt = debug_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= debug_port_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_r <= 8'h00;
      addr_r <= 7'h00;
      dir_rd_r <= 1'b0;
      sep_hi_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_r <= rx_nxt;
      addr_r <= addr_nxt;
      dir_rd_r <= dir_rd_nxt;
      sep_hi_r <= sep_hi_nxt;
    end
  end

  // ----------------------------------------
  // Debug register access
  // ----------------------------------------
  // Accesses go out as plain reads and writes, so whatever side effects the
  // target has happen exactly as for a core access; nothing here gates the
  // system clock, so only the core is affected by a debug halt.
  debug_port_pkg::dbg_access_t req_nxt;
  logic load_pend_r;
  logic [7:0] tx_r;

  // Writes use the address before the step, reads the new one: the command's address first, then the stepped one
  assign req_nxt.wr = wr_go;
  assign req_nxt.rd = rd_go;
  assign req_nxt.addr = rd_go ? addr_nxt : addr_r;
  assign req_nxt.wdata = {rx_r[6:0], sda_lvl_r};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dbg_req <= '0;
      load_pend_r <= 1'b0;
      tx_r <= 8'h00;
    end
    else if (clk_en)
    begin
      dbg_req <= req_nxt;
      load_pend_r <= dbg_req.rd;
      if (load_pend_r)
      begin
        tx_r <= dbg_rdata;
      end
    end
  end

  // ----------------------------------------
  // Serial data driver
  // ----------------------------------------
  // Loading takes three cycles after the separator edge; the master's clock
  // high time must cover it, which the half-rate limit guarantees only when
  // the serial clock is well below that ceiling.
  wire drive_bit = in_data & dir_rd_r & ~at_sep;
  wire [2:0] tx_idx = ~bit_cnt_r[2:0];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      debug_serial_data_out <= 1'b1;
      debug_serial_data_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start_det)
      begin
        debug_serial_data_oe <= 1'b0;
      end
      else if (scl_fall)
      begin
        debug_serial_data_oe <= drive_bit;
        debug_serial_data_out <= drive_bit ? tx_r[tx_idx] : 1'b1;
      end
    end
  end

  // ----------------------------------------
  // External bus grant
  // ----------------------------------------
  logic grant_en_r;
  wire port_free = ~active | sep_hi_r;
  // Once granted, the grant is held until the request or enable drops
  wire grant_nxt = grant_en_r & req_lvl_r & (bus_grant_out | port_free);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bus_grant_out <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_grant_out <= grant_nxt;
    end
  end

  // ----------------------------------------
  // Local control and status port
  // ----------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == debug_port_pkg::CTRL_OFS);
  wire [7:0] ctrl_val = {7'h00, grant_en_r};
  wire [7:0] stat_val = {5'h00, dir_rd_r & active, ~port_free, bus_grant_out};
  wire [7:0] rd_mux = (reg_addr == debug_port_pkg::CTRL_OFS) ? ctrl_val :
                      (reg_addr == debug_port_pkg::STAT_OFS) ? stat_val : 8'h00;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      grant_en_r <= debug_port_pkg::CTRL_GRANT_EN_RST;
      reg_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        grant_en_r <= reg_wdata[debug_port_pkg::CTRL_GRANT_EN_BIT];
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_start_enters_cmd;
    clk_en && start_det |=> in_cmd && bit_cnt_r == 4'h0 && !sep_hi_r;
  endproperty
  a_start_enters_cmd: assert property (p_start_enters_cmd)
    else $error("start did not open a command");

  property p_idle_ignores;
    state_r == debug_port_pkg::ST_IDLE && !start_det |=> state_r == debug_port_pkg::ST_IDLE;
  endproperty
  a_idle_ignores: assert property (p_idle_ignores)
    else $error("left idle without a start");

  property p_rise_no_effect;
    clk_en && sda_rise_hi |=> $stable(state_r) && $stable(bit_cnt_r) && $stable(rx_r);
  endproperty
  a_rise_no_effect: assert property (p_rise_no_effect)
    else $error("data rise with clock high changed state");

  property p_nine_slots;
    clk_en && bit_edge && at_sep |=> bit_cnt_r == 4'h0 && in_data;
  endproperty
  a_nine_slots: assert property (p_nine_slots)
    else $error("bit counter did not wrap after the separator");

  property p_write_strobe;
    clk_en && bit_edge && in_data && !dir_rd_r && at_last
      |=> dbg_req.wr && dbg_req.addr == $past(addr_r) && dbg_req.wdata[0] == $past(sda_lvl_r)
      ##1 !dbg_req.wr;
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe wrong after eighth bit");

  property p_write_step;
    clk_en && bit_edge && in_data && !dir_rd_r && at_last
      |=> addr_r == (($past(addr_r) == debug_port_pkg::WR_TOP) ? $past(addr_r)
                     : $past(addr_r) + 7'h01);
  endproperty
  a_write_step: assert property (p_write_step)
    else $error("write address step or cap wrong");

  property p_read_step;
    clk_en && bit_edge && in_data && dir_rd_r && at_sep
      |=> dbg_req.rd && addr_r == (($past(addr_r) == debug_port_pkg::RD_TOP) ? $past(addr_r)
                                   : $past(addr_r) + 7'h01);
  endproperty
  a_read_step: assert property (p_read_step)
    else $error("read address step or cap wrong");

  sequence s_read_cmd;
    clk_en && bit_edge && in_cmd && at_sep && rx_r[0];
  endsequence
  sequence s_read_load;
    dbg_req.rd && dbg_req.addr == $past(rx_r[7:1]) ##1 clk_en ##1 tx_r == $past(dbg_rdata);
  endsequence
  property p_read_load;
    s_read_cmd |=> s_read_load;
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read command did not load the shifter");

  property p_drive_fall;
    clk_en && scl_fall && !start_det && drive_bit
      |=> debug_serial_data_oe && debug_serial_data_out == $past(tx_r[tx_idx]);
  endproperty
  a_drive_fall: assert property (p_drive_fall)
    else $error("read bit not driven on falling edge");

  property p_grant_disabled;
    clk_en && !grant_en_r |=> !bus_grant_out;
  endproperty
  a_grant_disabled: assert property (p_grant_disabled)
    else $error("grant while disabled");

  property p_grant_withheld;
    clk_en && !port_free && !bus_grant_out |=> !bus_grant_out;
  endproperty
  a_grant_withheld: assert property (p_grant_withheld)
    else $error("grant while shifting");

  property p_grant_free;
    clk_en && grant_en_r && req_lvl_r && port_free |=> bus_grant_out;
  endproperty
  a_grant_free: assert property (p_grant_free)
    else $error("grant not given while free");

endmodule : two_wire_debug_port

// ### verification/adapter_model.sv
`timescale 1ns/1ps
module adapter_model
(
  output logic serial_clock,
  output logic pull_low,
  input wire logic line_level
);
  // 80 ns bit period keeps the serial clock far below half the system clock
  localparam int HALF_NS = 40;

  initial
  begin
    serial_clock = 1'h1;
    pull_low = 1'h0;
  end

  // ----------------------------------------
  // Frame primitives
  // ----------------------------------------
  task automatic start_cond();
    pull_low = 1'h0;
    #(HALF_NS);
    pull_low = 1'h1;
    #(HALF_NS);
  endtask : start_cond

  // Data moves mid-low; sampled just before the next fall, so a late driver is still seen
  task automatic slot(input logic drv, input logic v, input int low_ns, output logic seen);
    serial_clock = 1'h0;
    #(low_ns / 2);
    pull_low = drv & ~v;
    #(low_ns - low_ns / 2);
    serial_clock = 1'h1;
    #(HALF_NS - 1);
    seen = line_level;
    #1;
  endtask : slot

  // Reads stretch the separator low time so the port has released the line by then
  task automatic xfer(input logic [7:0] tx, input logic drv, input logic sep, input int gap_ns,
                      output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      slot(drv, tx[i], HALF_NS, s);
      rx[i] = s;
    end
    slot(1'h1, sep, drv ? HALF_NS : HALF_NS + 20, s);
    #(gap_ns);
  endtask : xfer
endmodule : adapter_model

// ### verification/two_wire_debug_port_tb.sv
`timescale 1ns/1ps
module two_wire_debug_port_tb;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clk_en = 1'h1;
  logic serial_clock;
  logic pull_low;
  logic line_level;
  logic data_out;
  logic data_oe;
  debug_port_pkg::dbg_access_t dbg_req;
  logic [7:0] dbg_rdata = 8'h00;
  logic bus_request_in = 1'h0;
  logic bus_grant_out;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic [31:0] seed = 32'h4103;
  logic [7:0] rx;
  logic [14:0] wr_q[$];
  logic [6:0] rd_q[$];
  int failures = 0;
  int check_count = 0;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  function automatic logic [7:0] rd_val(input logic [6:0] a);
    return {1'h1, a} ^ 8'h3c;
  endfunction : rd_val

  function automatic logic [6:0] next_addr(input logic [6:0] a, input logic [6:0] top);
    return (a == top) ? a : a + 7'h01;
  endfunction : next_addr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic wait_grant(input logic v);
    int n;
    n = 0;
    while (bus_grant_out !== v && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(16'(n < 50), 16'h1);
    if (n >= 50)
      wrap_up();
  endtask : wait_grant

  task automatic do_write(input logic [6:0] a, input int n);
    logic [14:0] e_q[$];
    logic [6:0] ea;
    ea = a;
    wr_q.delete();
    i_adapter_model.start_cond();
    i_adapter_model.xfer({a, 1'h0}, 1'h1, 1'h0, 0, rx);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      e_q.push_back({ea, seed[7:0]});
      ea = next_addr(ea, debug_port_pkg::WR_TOP);
      i_adapter_model.xfer(seed[7:0], 1'h1, 1'(i == n - 1), 0, rx);
    end
    repeat (10) @(posedge ref_clk);
    chk(16'(wr_q.size()), 16'(n));
    for (int i = 0; i < n; i++)
      chk(16'(wr_q[i]), 16'(e_q[i]));
  endtask : do_write

  task automatic do_read(input logic [6:0] a, input int n);
    logic [6:0] ea;
    ea = a;
    wr_q.delete();
    rd_q.delete();
    i_adapter_model.start_cond();
    i_adapter_model.xfer({a, 1'h1}, 1'h1, 1'h0, 100, rx);
    for (int i = 0; i < n; i++)
    begin
      i_adapter_model.xfer(8'hff, 1'h0, 1'(i == n - 1), 100, rx);
      chk(16'(rx), 16'(rd_val(ea)));
      chk(16'(rd_q[i]), 16'(ea));
      ea = next_addr(ea, debug_port_pkg::RD_TOP);
    end
    chk(16'(wr_q.size()), 16'h0);
    // Status: read operation open, last separator high so not busy, no grant
    reg_read(2'h1, rx);
    chk(16'(rx), 16'h04);
  endtask : do_read

  // Open-drain data line with a pull-up: released means high
  assign line_level = ~pull_low & (data_oe ? data_out : 1'h1);

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  two_wire_debug_port i_two_wire_debug_port
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .debug_serial_clock(serial_clock),
    .debug_serial_data_in(line_level),
    .debug_serial_data_out(data_out),
    .debug_serial_data_oe(data_oe),
    .dbg_req(dbg_req),
    .dbg_rdata(dbg_rdata),
    .bus_request_in(bus_request_in),
    .bus_grant_out(bus_grant_out),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  adapter_model i_adapter_model
  (
    .serial_clock(serial_clock),
    .pull_low(pull_low),
    .line_level(line_level)
  );

  // Register space stand-in: answers the cycle after a read, toggles otherwise
  always @(posedge ref_clk)
  begin
    dbg_rdata <= dbg_req.rd ? rd_val(dbg_req.addr) : ~dbg_rdata;
    if (dbg_req.wr)
      wr_q.push_back({dbg_req.addr, dbg_req.wdata});
    if (dbg_req.rd)
      rd_q.push_back(dbg_req.addr);
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk(16'(bus_grant_out), 16'h0);
    sys_rst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
    begin
      seed = lfsr(seed);
      i_adapter_model.slot(1'h1, seed[0], 40, rx[0]);
    end
    i_adapter_model.slot(1'h1, 1'h0, 40, rx[0]);
    i_adapter_model.pull_low = 1'h0;
    #100;
    chk(16'(wr_q.size() + rd_q.size()), 16'h0);
    chk(16'(data_oe), 16'h0);
    reg_read(2'h0, rx);
    chk(16'(rx), 16'h0);
    bus_request_in <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk(16'(bus_grant_out), 16'h0);
    reg_write(2'h2, 8'hff);
    reg_read(2'h2, rx);
    chk(16'(rx), 16'h0);
    reg_write(2'h0, 8'h01);
    wait_grant(1'h1);
    reg_read(2'h1, rx);
    chk(16'(rx[0]), 16'h1);
    // A frozen clock enable must hold the grant although the request drops
    @(posedge ref_clk);
    clk_en <= 1'h0;
    bus_request_in <= 1'h0;
    repeat (10) @(posedge ref_clk);
    chk(16'(bus_grant_out), 16'h1);
    clk_en <= 1'h1;
    wait_grant(1'h0);
    // Low separators inside a command must hold the grant back
    i_adapter_model.start_cond();
    i_adapter_model.xfer(8'h20, 1'h1, 1'h0, 0, rx);
    bus_request_in <= 1'h1;
    i_adapter_model.xfer(8'h5a, 1'h1, 1'h0, 0, rx);
    chk(16'(bus_grant_out), 16'h0);
    // Status: write operation still shifting, so busy and no grant
    reg_read(2'h1, rx);
    chk(16'(rx), 16'h02);
    i_adapter_model.xfer(8'ha5, 1'h1, 1'h1, 0, rx);
    wait_grant(1'h1);
    bus_request_in <= 1'h0;
    wait_grant(1'h0);
    do_write(7'h2e, 4);
    do_write(7'h03, 1);
    do_read(7'h03, 1);
    do_read(7'h1e, 4);
    repeat (3)
    begin
      seed = lfsr(seed);
      do_write({2'h0, seed[12:8]}, 2);
      do_read({2'h0, seed[20:16]}, 2);
    end
    wrap_up();
  end
endmodule : two_wire_debug_port_tb
